/* rtl/bififo_pkg.sv */
// Shared constants and carrier types of the bidirectional FIFO port block.
// Assumes both ports are sampled on the one system clock.
package bififo_pkg;

  localparam int DATA_W = 36;
  localparam int DEFAULT_DEPTH = 256;
  // Preset almost-full/almost-empty offsets chosen by the select straps.
  localparam int PRESET_OFFSET_0 = 8;
  localparam int PRESET_OFFSET_1 = 16;
  localparam int PRESET_OFFSET_2 = 64;
  // Number of port A words that program the offsets after a joint reset.
  localparam logic [2:0] PROG_WORDS = 3'h4;
  // Order in which programming words land in the offset registers.
  localparam logic [2:0] PROG_IDX_AE_B = 3'h0;
  localparam logic [2:0] PROG_IDX_AE_A = 3'h1;
  localparam logic [2:0] PROG_IDX_AF_A = 3'h2;
  // Encodings of the two offset select straps {hi, lo}.
  localparam logic [1:0] SEL_PROGRAM = 2'h0;
  localparam logic [1:0] SEL_PRESET_0 = 2'h1;
  localparam logic [1:0] SEL_PRESET_1 = 2'h2;

  // Control pins of one port, sampled on the rising clock edge.
  typedef struct packed {
    logic selectN;
    logic enable;
    logic direction;
    logic mailboxSelect;
  } portCtrl_s;

endpackage : bififo_pkg

/* rtl/bififo_mailbox.sv */
// One mailbox bypass register with its new-mail flag.
// Assumes write and read strobes are already qualified by the port controls.
`timescale 1ns/1ps
module bififo_mailbox #(
  parameter int W = bififo_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrReq,
  input wire logic [W-1:0] wrData,
  input wire logic rdReq,
  output logic flagN,
  output logic [W-1:0] word
);
  import bififo_pkg::*;

  typedef struct packed {
    logic flagN;
    logic [W-1:0] word;
  } mbState_s;

  mbState_s s_r;
  mbState_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    // A read releases the box; a write in the same edge wins only if the box was already empty.
    if (rdReq) begin
      s_nxt.flagN = 1'b1;
    end
    if (wrReq && s_r.flagN) begin
      s_nxt.word = wrData;
      s_nxt.flagN = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.flagN <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flagN = s_r.flagN;
  assign word = s_r.word;

endmodule : bififo_mailbox

/* rtl/bififo_queue.sv */
// One FIFO direction: flop storage, output register and its four flags.
// Assumes wrEn only while inputReady is high and rdEn only while outputReady is high.
`timescale 1ns/1ps
module bififo_queue #(
  parameter int W = bififo_pkg::DATA_W,
  parameter int DEPTH = bififo_pkg::DEFAULT_DEPTH,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic [W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW:0] aeOffset,
  input wire logic [AW:0] afOffset,
  output logic inputReady,
  output logic outputReady,
  output logic almostFullN,
  output logic almostEmptyN,
  output logic [W-1:0] outWord
);
  import bififo_pkg::*;

  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [AW:0] wpD1;
    logic [AW:0] wpD2;
    logic [AW:0] rpD1;
    logic [AW:0] rpD2;
    logic settle;
    logic ir;
    logic orr;
    logic afN;
    logic aeN;
    logic [W-1:0] outWord;
  } qState_s;

  qState_s s_r;
  qState_s s_nxt;
  logic [W-1:0] mem [DEPTH];

  always_comb begin
    logic [AW:0] fill;
    logic [AW:0] words;
    fill = '0;
    words = '0;
    s_nxt = s_r;
    if (wrEn) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    // Each side sees the other's pointer two stages late, as a crossing would.
    s_nxt.wpD1 = s_r.wp;
    s_nxt.wpD2 = s_r.wpD1;
    s_nxt.rpD1 = s_r.rp;
    s_nxt.rpD2 = s_r.rpD1;
    s_nxt.settle = 1'b1;
    // Output register refills when consumed or empty: third edge after a write.
    if (rdEn || !s_r.orr) begin
      if (s_r.wpD2 != s_r.rp) begin
        s_nxt.outWord = mem[s_r.rp[AW-1:0]];
        s_nxt.rp = s_r.rp + 1'b1;
        s_nxt.orr = 1'b1;
      end else begin
        s_nxt.orr = 1'b0;
      end
    end
    fill = s_nxt.wp - s_nxt.rpD2;
    // Input ready rises on the second edge after reset, low when full.
    s_nxt.ir = s_r.settle && (fill != DEPTH_W);
    s_nxt.afN = (DEPTH_W - fill) > afOffset;
    words = (s_nxt.wpD2 - s_nxt.rp) + {{AW{1'b0}}, s_nxt.orr};
    s_nxt.aeN = words > aeOffset;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[s_r.wp[AW-1:0]] <= wrData;
    end
  end

  assign inputReady = s_r.ir;
  assign outputReady = s_r.orr;
  assign almostFullN = s_r.afN;
  assign almostEmptyN = s_r.aeN;
  assign outWord = s_r.outWord;

endmodule : bififo_queue

/* rtl/bififo_top.sv */
// Port control, flags and mailboxes of a bidirectional two-queue FIFO.
// Assumes both ports run on clk and their control pins are synchronous to it.
`timescale 1ns/1ps
module bififo_top #(
  parameter int DEPTH = bififo_pkg::DEFAULT_DEPTH,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire bififo_pkg::portCtrl_s portACtrl,
  input wire bififo_pkg::portCtrl_s portBCtrl,
  input wire logic aToBFifoResetN,
  input wire logic bToAFifoResetN,
  input wire logic offsetSelectLo,
  input wire logic offsetSelectHi,
  input wire logic [bififo_pkg::DATA_W-1:0] portADataIn,
  output logic [bififo_pkg::DATA_W-1:0] portADataOut,
  output logic portADataOe,
  input wire logic [bififo_pkg::DATA_W-1:0] portBDataIn,
  output logic [bififo_pkg::DATA_W-1:0] portBDataOut,
  output logic portBDataOe,
  output logic aSideInputReady,
  output logic bSideInputReady,
  output logic aSideOutputReady,
  output logic bSideOutputReady,
  output logic aSideAlmostEmptyN,
  output logic aSideAlmostFullN,
  output logic bSideAlmostEmptyN,
  output logic bSideAlmostFullN,
  output logic aToBMailFlagN,
  output logic bToAMailFlagN
);
  import bififo_pkg::*;

  // Presets beyond what the flag counters hold saturate, so they never wrap to a small offset.
  localparam int OFFSET_MAX = (2 ** (AW + 1)) - 1;
  localparam int PRESET_C_0 = (PRESET_OFFSET_0 > OFFSET_MAX) ? OFFSET_MAX : PRESET_OFFSET_0;
  localparam int PRESET_C_1 = (PRESET_OFFSET_1 > OFFSET_MAX) ? OFFSET_MAX : PRESET_OFFSET_1;
  localparam int PRESET_C_2 = (PRESET_OFFSET_2 > OFFSET_MAX) ? OFFSET_MAX : PRESET_OFFSET_2;
  localparam logic [AW:0] PRESET_W_0 = (AW+1)'(PRESET_C_0);
  localparam logic [AW:0] PRESET_W_1 = (AW+1)'(PRESET_C_1);
  localparam logic [AW:0] PRESET_W_2 = (AW+1)'(PRESET_C_2);

  typedef struct packed {
    logic aToBResetPrev;
    logic bToAResetPrev;
    logic progActive;
    logic [2:0] progCount;
    logic [AW:0] aToBEmptyOffset;
    logic [AW:0] aToBFullOffset;
    logic [AW:0] bToAEmptyOffset;
    logic [AW:0] bToAFullOffset;
    logic [DATA_W-1:0] aOut;
    logic [DATA_W-1:0] bOut;
    logic aOe;
    logic bOe;
  } topState_s;

  topState_s s_r;
  topState_s s_nxt;

  logic aActive;
  logic bActive;
  logic aWrite;
  logic bWrite;
  logic aQueueWrite;
  logic aToBQueueWrite;
  logic aQueueRead;
  logic bQueueWrite;
  logic bQueueRead;
  logic aMailWrite;
  logic aMailRead;
  logic bMailWrite;
  logic bMailRead;
  logic aToBRstN;
  logic bToARstN;
  logic aToBRise;
  logic bToARise;
  logic [1:0] straps;
  logic [AW:0] presetOffset;
  logic aToBIr;
  logic aToBOr;
  logic bToAIr;
  logic bToAOr;
  logic [DATA_W-1:0] aToBWord;
  logic [DATA_W-1:0] bToAWord;
  logic [DATA_W-1:0] aToBMailWord;
  logic [DATA_W-1:0] bToAMailWord;

  // An edge acts on a port only with select low and enable high.
  assign aActive = !portACtrl.selectN && portACtrl.enable;
  assign bActive = !portBCtrl.selectN && portBCtrl.enable;
  assign aWrite = portACtrl.direction;
  assign bWrite = !portBCtrl.direction;

  assign aQueueWrite = aActive && aWrite && !portACtrl.mailboxSelect && aToBIr;
  assign aQueueRead = aActive && !aWrite && !portACtrl.mailboxSelect && bToAOr;
  assign bQueueWrite = bActive && bWrite && !portBCtrl.mailboxSelect && bToAIr;
  assign bQueueRead = bActive && !bWrite && !portBCtrl.mailboxSelect && aToBOr;
  assign aMailWrite = aActive && aWrite && portACtrl.mailboxSelect;
  assign aMailRead = aActive && !aWrite && portACtrl.mailboxSelect;
  assign bMailWrite = bActive && bWrite && portBCtrl.mailboxSelect;
  assign bMailRead = bActive && !bWrite && portBCtrl.mailboxSelect;

  // Programming words go to the offset registers, never into the queue.
  assign aToBQueueWrite = aQueueWrite && !s_r.progActive;

  assign aToBRstN = rstn && aToBFifoResetN;
  assign bToARstN = rstn && bToAFifoResetN;
  assign aToBRise = aToBFifoResetN && !s_r.aToBResetPrev;
  assign bToARise = bToAFifoResetN && !s_r.bToAResetPrev;
  assign straps = {offsetSelectHi, offsetSelectLo};

  always_comb begin
    if (straps == SEL_PRESET_0) begin
      presetOffset = PRESET_W_0;
    end else if (straps == SEL_PRESET_1) begin
      presetOffset = PRESET_W_1;
    end else begin
      presetOffset = PRESET_W_2;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.aToBResetPrev = aToBFifoResetN;
    s_nxt.bToAResetPrev = bToAFifoResetN;
    if (!aToBFifoResetN || !bToAFifoResetN) begin
      s_nxt.progActive = 1'b0;
      s_nxt.progCount = '0;
    end
    if (aToBRise && straps != SEL_PROGRAM) begin
      s_nxt.aToBEmptyOffset = presetOffset;
      s_nxt.aToBFullOffset = presetOffset;
    end
    if (bToARise && straps != SEL_PROGRAM) begin
      s_nxt.bToAEmptyOffset = presetOffset;
      s_nxt.bToAFullOffset = presetOffset;
    end
    // Programming is armed only when both queues leave reset on one edge.
    if (aToBRise && bToARise && straps == SEL_PROGRAM) begin
      s_nxt.progActive = 1'b1;
      s_nxt.progCount = '0;
    end
    if (s_r.progActive && aQueueWrite) begin
      if (s_r.progCount == PROG_IDX_AE_B) begin
        s_nxt.aToBEmptyOffset = portADataIn[AW:0];
      end else if (s_r.progCount == PROG_IDX_AE_A) begin
        s_nxt.bToAEmptyOffset = portADataIn[AW:0];
      end else if (s_r.progCount == PROG_IDX_AF_A) begin
        s_nxt.aToBFullOffset = portADataIn[AW:0];
      end else begin
        s_nxt.bToAFullOffset = portADataIn[AW:0];
      end
      s_nxt.progCount = s_r.progCount + 3'h1;
      s_nxt.progActive = (s_r.progCount + 3'h1) != PROG_WORDS;
    end
    // Lines drive only for a selected read; registered, so one edge late.
    s_nxt.aOe = !portACtrl.selectN && !aWrite;
    s_nxt.bOe = !portBCtrl.selectN && !bWrite;
    s_nxt.aOut = portACtrl.mailboxSelect ? bToAMailWord : bToAWord;
    s_nxt.bOut = portBCtrl.mailboxSelect ? aToBMailWord : aToBWord;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.aToBResetPrev <= 1'b1;
      s_r.bToAResetPrev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  bififo_queue #(
    .W(DATA_W),
    .DEPTH(DEPTH)
  ) aToBQueue (
    .clk(clk),
    .rstn(aToBRstN),
    .wrEn(aToBQueueWrite),
    .wrData(portADataIn),
    .rdEn(bQueueRead),
    .aeOffset(s_r.aToBEmptyOffset),
    .afOffset(s_r.aToBFullOffset),
    .inputReady(aToBIr),
    .outputReady(aToBOr),
    .almostFullN(aSideAlmostFullN),
    .almostEmptyN(bSideAlmostEmptyN),
    .outWord(aToBWord)
  );

  bififo_queue #(
    .W(DATA_W),
    .DEPTH(DEPTH)
  ) bToAQueue (
    .clk(clk),
    .rstn(bToARstN),
    .wrEn(bQueueWrite),
    .wrData(portBDataIn),
    .rdEn(aQueueRead),
    .aeOffset(s_r.bToAEmptyOffset),
    .afOffset(s_r.bToAFullOffset),
    .inputReady(bToAIr),
    .outputReady(bToAOr),
    .almostFullN(bSideAlmostFullN),
    .almostEmptyN(aSideAlmostEmptyN),
    .outWord(bToAWord)
  );

  bififo_mailbox #(
    .W(DATA_W)
  ) aToBMailbox (
    .clk(clk),
    .rstn(aToBRstN),
    .wrReq(aMailWrite),
    .wrData(portADataIn),
    .rdReq(bMailRead),
    .flagN(aToBMailFlagN),
    .word(aToBMailWord)
  );

  bififo_mailbox #(
    .W(DATA_W)
  ) bToAMailbox (
    .clk(clk),
    .rstn(bToARstN),
    .wrReq(bMailWrite),
    .wrData(portBDataIn),
    .rdReq(aMailRead),
    .flagN(bToAMailFlagN),
    .word(bToAMailWord)
  );

  assign aSideInputReady = aToBIr;
  assign bSideInputReady = bToAIr;
  assign aSideOutputReady = bToAOr;
  assign bSideOutputReady = aToBOr;
  assign portADataOut = s_r.aOut;
  assign portADataOe = s_r.aOe;
  assign portBDataOut = s_r.bOut;
  assign portBDataOe = s_r.bOe;

endmodule : bififo_top

/* testbench/bififo_props.sv */
// Concurrent checks on the ports of the bidirectional FIFO block.
// Assumes one clk domain and the synchronous active-low rstn.
`timescale 1ns/1ps
module bififo_props
  import bififo_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire portCtrl_s portACtrl,
  input wire portCtrl_s portBCtrl,
  input wire logic aToBFifoResetN,
  input wire logic bToAFifoResetN,
  input wire logic portADataOe,
  input wire logic portBDataOe,
  input wire logic aSideInputReady,
  input wire logic aSideOutputReady,
  input wire logic aToBMailFlagN,
  input wire logic bToAMailFlagN
);
  logic aAcc, bAcc, aMbW, aMbR, bMbW, bMbR, bQWr;
  logic [2:0] idle_r;
  assign aAcc = !portACtrl.selectN && portACtrl.enable;
  assign bAcc = !portBCtrl.selectN && portBCtrl.enable;
  assign aMbW = aAcc && portACtrl.direction && portACtrl.mailboxSelect && aToBFifoResetN;
  assign aMbR = aAcc && !portACtrl.direction && portACtrl.mailboxSelect;
  assign bMbW = bAcc && !portBCtrl.direction && portBCtrl.mailboxSelect && bToAFifoResetN;
  assign bMbR = bAcc && portBCtrl.direction && portBCtrl.mailboxSelect;
  assign bQWr = bAcc && !portBCtrl.direction && !portBCtrl.mailboxSelect && bToAFifoResetN;
  // A saturated count of quiet cycles proves nothing is still in flight to the A side.
  always_ff @(posedge clk) begin
    if (!rstn || bQWr) begin
      idle_r <= 3'h0;
    end else if (idle_r != 3'h7) begin
      idle_r <= idle_r + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_b_lines_off: assert property ($past(portBCtrl.selectN) |-> !portBDataOe)
    else $error("port B lines driven while deselected");
  a_a_lines_off: assert property ($past(portACtrl.selectN || portACtrl.direction) |-> !portADataOe)
    else $error("port A lines driven while deselected or writing");
  a_b_dir_off: assert property ($past(!portBCtrl.direction) |-> !portBDataOe)
    else $error("port B lines driven while writing");
  a_ira_release: assert property ($rose(aToBFifoResetN) |-> !aSideInputReady [*2] ##1 aSideInputReady)
    else $error("A input ready wrong after queue reset");
  a_ora_rise: assert property (bQWr && idle_r == 3'h7 && !aSideOutputReady
    |-> !aSideOutputReady [*4] ##1 aSideOutputReady)
    else $error("A output ready wrong after first word");
  a_ora_reset: assert property (!bToAFifoResetN |=> !aSideOutputReady && bToAMailFlagN)
    else $error("queue reset did not clear A side flags");
  a_abmail_set: assert property (aMbW && aToBMailFlagN |=> !aToBMailFlagN)
    else $error("A mailbox write did not lower flag");
  a_abmail_clr: assert property (bMbR && !aMbW |=> aToBMailFlagN)
    else $error("B mailbox read did not raise flag");
  a_bamail_set: assert property (bMbW && bToAMailFlagN |=> !bToAMailFlagN)
    else $error("B mailbox write did not lower flag");
  a_bamail_clr: assert property (aMbR && !bMbW |=> bToAMailFlagN)
    else $error("A mailbox read did not raise flag");
  a_a_idle_flag: assert property (!aAcc && aToBMailFlagN |=> aToBMailFlagN)
    else $error("mail flag fell without an A access");
  a_b_idle_flag: assert property (!bAcc && bToAMailFlagN |=> bToAMailFlagN)
    else $error("mail flag fell without a B access");
  c_first_word: cover property (bQWr && idle_r == 3'h7);
  c_mail_read: cover property ($rose(aToBMailFlagN));
  c_ready_up: cover property ($rose(aSideInputReady));
endmodule : bififo_props
bind bififo_top bififo_props u_bififo_props (.clk, .rstn, .portACtrl, .portBCtrl, .aToBFifoResetN,
  .bToAFifoResetN, .portADataOe, .portBDataOe, .aSideInputReady, .aSideOutputReady,
  .aToBMailFlagN, .bToAMailFlagN);

/* testbench/port_master.sv */
// Bus master model of one port: drives its controls and write data onto the wire.
// Assumes the device samples on the rising clk edge; WR is the direction level of a write.
`timescale 1ns/1ps
module port_master
  import bififo_pkg::*;
#(
  parameter logic WR = 1'b1
) (
  input wire logic clk,
  input wire logic inputReady,
  input wire logic mailFlagN,
  input wire logic [DATA_W-1:0] dataOut,
  output portCtrl_s ctrl,
  output logic [DATA_W-1:0] dataIn
);
  initial begin
    ctrl = '{1'b1, 1'b0, WR, 1'b0};
    dataIn = '0;
  end
  // A random gap of one or two edges before each write request models a slow master.
  task automatic put(input logic [DATA_W-1:0] d, input logic mb, input logic en, output logic ok);
    repeat ($urandom_range(1, 2)) @(posedge clk);
    ctrl <= '{1'b0, en, WR, mb};
    dataIn <= d;
    @(posedge clk);
    ok = en && (mb ? mailFlagN : inputReady);
    ctrl <= '{1'b1, 1'b0, WR, 1'b0};
    // Released data is inverted so a stale word can never look valid.
    dataIn <= ~d;
  endtask : put
  task automatic get(input logic mb, output logic [DATA_W-1:0] d);
    @(posedge clk);
    ctrl <= '{1'b0, 1'b0, !WR, mb};
    repeat (2) @(posedge clk);
    d = dataOut;
    ctrl <= '{1'b0, 1'b1, !WR, mb};
    @(posedge clk);
    ctrl <= '{1'b1, 1'b0, WR, 1'b0};
  endtask : get
endmodule : port_master

/* testbench/testbench.sv */
// Self-checking bench: one master model per port, queues as the reference.
// Assumes the design, checker and master model are compiled first; DEPTH is cut to 8.
`timescale 1ns/1ps
module testbench;
  import bififo_pkg::*;
  localparam int DEPTH = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic aToBFifoResetN = 1'b0;
  logic bToAFifoResetN = 1'b0;
  logic offsetSelectLo = 1'b0;
  logic offsetSelectHi = 1'b0;
  portCtrl_s portACtrl, portBCtrl;
  logic [DATA_W-1:0] portADataIn, portADataOut, portBDataIn, portBDataOut, aDrv, bDrv, d, e;
  logic portADataOe, portBDataOe, aSideInputReady, bSideInputReady, aSideOutputReady;
  logic bSideOutputReady, aSideAlmostEmptyN, aSideAlmostFullN, bSideAlmostEmptyN;
  logic bSideAlmostFullN, aToBMailFlagN, bToAMailFlagN, ok, en;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  logic [DATA_W-1:0] qAB[$], qBA[$];
  always #5 clk = ~clk;
  assign portADataIn = portADataOe ? portADataOut : aDrv;
  assign portBDataIn = portBDataOe ? portBDataOut : bDrv;
  bififo_top #(.DEPTH(DEPTH)) u_bififo_top (.clk, .rstn, .portACtrl, .portBCtrl, .aToBFifoResetN,
    .bToAFifoResetN, .offsetSelectLo, .offsetSelectHi, .portADataIn, .portADataOut, .portADataOe,
    .portBDataIn, .portBDataOut, .portBDataOe, .aSideInputReady, .bSideInputReady,
    .aSideOutputReady, .bSideOutputReady, .aSideAlmostEmptyN, .aSideAlmostFullN,
    .bSideAlmostEmptyN, .bSideAlmostFullN, .aToBMailFlagN, .bToAMailFlagN);
  port_master #(.WR(1'b1)) u_port_master_a (.clk, .inputReady(aSideInputReady),
    .mailFlagN(aToBMailFlagN), .dataOut(portADataOut), .ctrl(portACtrl), .dataIn(aDrv));
  port_master #(.WR(1'b0)) u_port_master_b (.clk, .inputReady(bSideInputReady),
    .mailFlagN(bToAMailFlagN), .dataOut(portBDataOut), .ctrl(portBCtrl), .dataIn(bDrv));
  task automatic chkW(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chkW
  task automatic chkF(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkF
  task automatic done(input string name);
    $display("test %0s finished at %0t", name, $time);
  endtask : done
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'h03b8c841));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    aToBFifoResetN <= 1'b1;
    bToAFifoResetN <= 1'b1;
    @(posedge clk);
    chkF(aToBMailFlagN, 1'b1);
    chkF(bToAMailFlagN, 1'b1);
    chkF(aSideOutputReady, 1'b0);
    for (int i = 0; i < 9 && aSideInputReady !== 1'b1; i++) @(posedge clk);
    chkF(aSideInputReady, 1'b1);
    chkF(bSideInputReady, 1'b1);
    // Four zero words program every offset to zero and must not enter the queue.
    repeat (4) u_port_master_a.put('0, 1'b0, 1'b1, ok);
    repeat (6) @(posedge clk);
    chkF(bSideOutputReady, 1'b0);
    done("reset_and_program");
    d = DATA_W'({$urandom(), $urandom()});
    u_port_master_a.put(d, 1'b0, 1'b1, ok);
    qAB.push_back(d);
    n = 0;
    while (bSideOutputReady !== 1'b1 && n < 9) begin
      @(posedge clk);
      n++;
    end
    chkF(n == 4, 1'b1);
    chkF(bSideAlmostEmptyN, 1'b1);
    ok = 1'b1;
    for (int i = 0; i < 40 && ok; i++) begin
      en = $urandom_range(0, 3) != 0;
      d = DATA_W'({$urandom(), $urandom()});
      u_port_master_a.put(d, 1'b0, en, ok);
      if (ok) qAB.push_back(d);
      ok = ok || !en;
    end
    repeat (3) @(posedge clk);
    chkF(aSideInputReady, 1'b0);
    chkF(aSideAlmostFullN, 1'b0);
    while (qAB.size() > 0) begin
      for (int i = 0; i < 9 && bSideOutputReady !== 1'b1; i++) @(posedge clk);
      u_port_master_b.get(1'b0, e);
      chkW(e, qAB.pop_front());
    end
    repeat (3) @(posedge clk);
    chkF(bSideOutputReady, 1'b0);
    chkF(bSideAlmostEmptyN, 1'b0);
    done("a_to_b_stream");
    ok = 1'b1;
    for (int i = 0; i < 40 && ok; i++) begin
      d = DATA_W'({$urandom(), $urandom()});
      u_port_master_b.put(d, 1'b0, 1'b1, ok);
      if (ok) qBA.push_back(d);
    end
    repeat (3) @(posedge clk);
    chkF(bSideInputReady, 1'b0);
    chkF(aSideAlmostEmptyN, 1'b1);
    chkF(bSideAlmostFullN, 1'b0);
    while (qBA.size() > 0) begin
      for (int i = 0; i < 9 && aSideOutputReady !== 1'b1; i++) @(posedge clk);
      u_port_master_a.get(1'b0, e);
      chkW(e, qBA.pop_front());
    end
    repeat (3) @(posedge clk);
    chkF(aSideOutputReady, 1'b0);
    chkF(bSideInputReady, 1'b1);
    chkF(bSideAlmostFullN, 1'b1);
    chkF(aSideAlmostEmptyN, 1'b0);
    done("b_to_a_fill");
    d = DATA_W'({$urandom(), $urandom()});
    u_port_master_a.put(d, 1'b1, 1'b1, ok);
    u_port_master_a.put(~d, 1'b1, 1'b1, ok);
    chkF(aToBMailFlagN, 1'b0);
    u_port_master_b.get(1'b1, e);
    chkW(e, d);
    @(posedge clk);
    chkF(aToBMailFlagN, 1'b1);
    u_port_master_b.put(d, 1'b1, 1'b1, ok);
    u_port_master_b.put(~d, 1'b1, 1'b1, ok);
    chkF(bToAMailFlagN, 1'b0);
    u_port_master_a.get(1'b1, e);
    chkW(e, d);
    @(posedge clk);
    chkF(bToAMailFlagN, 1'b1);
    done("mailboxes");
    u_port_master_a.put(d, 1'b0, 1'b1, ok);
    for (int i = 0; i < 9 && bSideOutputReady !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chkF(aSideAlmostFullN, 1'b1);
    offsetSelectLo <= 1'b1;
    aToBFifoResetN <= 1'b0;
    repeat (4) @(posedge clk);
    chkF(bSideOutputReady, 1'b0);
    aToBFifoResetN <= 1'b1;
    for (int i = 0; i < 9 && aSideInputReady !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chkF(aSideAlmostFullN, 1'b0);
    // The high strap picks a preset above the depth, so the B side is always almost full.
    offsetSelectLo <= 1'b0;
    offsetSelectHi <= 1'b1;
    bToAFifoResetN <= 1'b0;
    repeat (4) @(posedge clk);
    bToAFifoResetN <= 1'b1;
    repeat (6) @(posedge clk);
    chkF(bSideAlmostFullN, 1'b0);
    done("preset_offsets");
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : testbench
